// >>> verilog/vic_nest_defs.svh
`ifndef VIC_NEST_DEFS_SVH
`define VIC_NEST_DEFS_SVH

`define ADDR_NORMAL_VECTOR 32'hFFFF001C
`define ADDR_PRIORITY_SET_C 32'hFFFF0028
`define ADDR_NESTING_CONTROL 32'hFFFF0030
`define ADDR_EXT_TRIG_CONFIG 32'hFFFF0034
`define ADDR_EDGE_CLEAR 32'hFFFF0038
`define ADDR_NORMAL_STACK 32'hFFFF003C
`define ADDR_FAST_VECTOR 32'hFFFF011C
`define ADDR_FAST_STACK 32'hFFFF013C

`define EXT3_PRI_LSB 12
`define EXT2_PRI_LSB 8
`define SPI_SLAVE_PRI_LSB 4
`define I2C_SLAVE_PRI_LSB 0

`define NORMAL_NEST_BIT 0
`define FAST_NEST_BIT 1

`define EDGE_CLR3_BIT 19
`define EDGE_CLR2_BIT 18
`define EDGE_CLR1_BIT 14
`define EDGE_CLR0_BIT 13

`define SRC_SPI_SLAVE 10
`define SRC_I2C_SLAVE 14
`define SRC_EXT2 16
`define SRC_EXT3 17
`define NUM_SOURCES 20

`define RST_PRIORITY_SET_C 15'h0000
`define RST_NESTING_CONTROL 2'h0
`define RST_EXT_TRIG_CONFIG 8'h00
`define RST_STACK 8'h00

`endif

// >>> verilog/vic_nest_pkg.sv
package vic_nest_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic valid;
      logic [4:0] idx;
      logic [2:0] level;
   } pick_type;

   typedef enum logic [1:0] {
      TRIG_HIGH = 2'b00,
      TRIG_LOW = 2'b01,
      TRIG_RISE = 2'b10,
      TRIG_FALL = 2'b11
   } trig_mode_type;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_DONE = 2'b10
   } bus_state_type;
endpackage : vic_nest_pkg

// >>> verilog/vectored_interrupt_nesting.sv
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`include "vic_nest_defs.svh"

module vectored_interrupt_nesting (
   input wire logic clk,
   input wire logic rst,
   input vic_nest_pkg::apb_req_type apb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [19:0] normal_active,
   input wire logic [19:0] fast_active,
   input wire logic [59:0] other_levels,
   input wire logic [15:0] vector_base,
   input wire logic [3:0] ext_int,
   output logic [3:0] ext_request,
   output logic normal_irq,
   output logic [4:0] normal_source,
   output logic fast_irq,
   output logic [4:0] fast_source
);
   import vic_nest_pkg::*;

   logic [14:0] priority_set_c;
   logic [1:0] nesting_control;
   logic [7:0] external_trigger_config;
   logic [7:0] normal_inservice_stack;
   logic [7:0] fast_inservice_stack;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] sync3;
   logic [3:0] ext_level;
   logic [3:0] edge_pending;
   logic [3:0] edge_seen;
   logic [3:0] edge_clear;
   bus_state_type bus_state;
   pick_type normal_pick;
   pick_type fast_pick;
   pick_type cap_pick;
   pick_type next_normal_pick;
   pick_type next_fast_pick;
   logic [59:0] levels;
   logic [31:0] rd_data;
   logic rd_err;
   logic done;
   logic wr;
   logic rd;

   // mask of stack bits at or more urgent than a level
   function automatic logic [7:0] upto_mask(input logic [2:0] lvl);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (3'(i) <= lvl) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction : upto_mask

   // most urgent unblocked source, or lowest active index with nesting off; lowest index wins a tie
   function automatic pick_type pick(input logic [19:0] act, input logic [59:0] lv,
                                     input logic [7:0] stack, input logic nest);
      pick_type p;
      logic [2:0] l;
      p = '0;
      for (int i = 0; i < `NUM_SOURCES; i++) begin
         l = lv[3*i +: 3];
         if (act[i]) begin
            if (!nest) begin
               if (!p.valid) begin
                  p = '{1'b1, 5'(i), 3'h0};
               end
            end else if ((stack & upto_mask(l)) == 8'h00) begin
               if (!p.valid || l < p.level) begin
                  p = '{1'b1, 5'(i), l};
               end
            end
         end
      end
      return p;
   endfunction : pick

   always_comb begin
      levels = other_levels;
      levels[3*`SRC_EXT3 +: 3] = priority_set_c[`EXT3_PRI_LSB +: 3];
      levels[3*`SRC_EXT2 +: 3] = priority_set_c[`EXT2_PRI_LSB +: 3];
      levels[3*`SRC_SPI_SLAVE +: 3] = priority_set_c[`SPI_SLAVE_PRI_LSB +: 3];
      levels[3*`SRC_I2C_SLAVE +: 3] = priority_set_c[`I2C_SLAVE_PRI_LSB +: 3];
      next_normal_pick = pick(normal_active, levels, normal_inservice_stack,
                              nesting_control[`NORMAL_NEST_BIT]);
      next_fast_pick = pick(fast_active, levels, fast_inservice_stack,
                            nesting_control[`FAST_NEST_BIT]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         normal_pick <= '0;
         fast_pick <= '0;
         normal_irq <= 1'b0;
         fast_irq <= 1'b0;
         normal_source <= 5'h00;
         fast_source <= 5'h00;
      end else begin
         normal_pick <= next_normal_pick;
         fast_pick <= next_fast_pick;
         fast_irq <= next_fast_pick.valid;
         fast_source <= next_fast_pick.idx;
         // a fast request always wins over a normal one
         normal_irq <= next_normal_pick.valid && !next_fast_pick.valid;
         normal_source <= next_normal_pick.idx;
      end
   end

   // one wait state so read data and answer both leave flops
   assign done = (bus_state == BUS_DONE) && apb.psel && apb.penable;
   assign wr = done && apb.pwrite;
   assign rd = done && !apb.pwrite;

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (apb.paddr == `ADDR_PRIORITY_SET_C) begin
         rd_data = {17'h0, priority_set_c} & 32'h0000_7777;
      end else if (apb.paddr == `ADDR_NESTING_CONTROL) begin
         rd_data = {30'h0, nesting_control};
      end else if (apb.paddr == `ADDR_EXT_TRIG_CONFIG) begin
         rd_data = {24'h00_0000, external_trigger_config};
      end else if (apb.paddr == `ADDR_EDGE_CLEAR) begin
         rd_data = 32'h0000_0000;
      end else if (apb.paddr == `ADDR_NORMAL_STACK) begin
         rd_data = {24'h00_0000, normal_inservice_stack};
      end else if (apb.paddr == `ADDR_FAST_STACK) begin
         rd_data = {24'h00_0000, fast_inservice_stack};
      end else if (apb.paddr == `ADDR_NORMAL_VECTOR) begin
         rd_data = {9'h0, vector_base, normal_pick.idx, 2'b00};
      end else if (apb.paddr == `ADDR_FAST_VECTOR) begin
         rd_data = {9'h0, vector_base, fast_pick.idx, 2'b00};
      end else begin
         rd_err = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_state <= BUS_IDLE;
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         cap_pick <= '0;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (apb.psel && apb.penable) begin
                  bus_state <= BUS_DONE;
                  pready <= 1'b1;
                  prdata <= apb.pwrite ? 32'h0000_0000 : rd_data;
                  pslverr <= rd_err;
                  // the level pushed is the one software was shown
                  cap_pick <= (apb.paddr == `ADDR_FAST_VECTOR) ? fast_pick : normal_pick;
               end
            end
            BUS_DONE: begin
               bus_state <= BUS_IDLE;
               pready <= 1'b0;
               pslverr <= 1'b0;
            end
            default: begin
               bus_state <= BUS_IDLE;
               pready <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         priority_set_c <= `RST_PRIORITY_SET_C;
         nesting_control <= `RST_NESTING_CONTROL;
         external_trigger_config <= `RST_EXT_TRIG_CONFIG;
      end else if (wr) begin
         if (apb.paddr == `ADDR_PRIORITY_SET_C) begin
            priority_set_c <= apb.pwdata[14:0] & 15'h7777;
         end else if (apb.paddr == `ADDR_NESTING_CONTROL) begin
            nesting_control <= apb.pwdata[1:0];
         end else if (apb.paddr == `ADDR_EXT_TRIG_CONFIG) begin
            external_trigger_config <= apb.pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         normal_inservice_stack <= `RST_STACK;
      end else if (wr && apb.paddr == `ADDR_NORMAL_STACK) begin
         normal_inservice_stack <= normal_inservice_stack & (normal_inservice_stack - 8'h01);
      end else if (rd && apb.paddr == `ADDR_NORMAL_VECTOR &&
                   nesting_control[`NORMAL_NEST_BIT] && cap_pick.valid) begin
         normal_inservice_stack <= normal_inservice_stack | (8'h01 << cap_pick.level);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fast_inservice_stack <= `RST_STACK;
      end else if (wr && apb.paddr == `ADDR_FAST_STACK) begin
         fast_inservice_stack <= fast_inservice_stack & (fast_inservice_stack - 8'h01);
      end else if (rd && apb.paddr == `ADDR_FAST_VECTOR &&
                   nesting_control[`FAST_NEST_BIT] && cap_pick.valid) begin
         fast_inservice_stack <= fast_inservice_stack | (8'h01 << cap_pick.level);
      end
   end

   // a change counts only once two late stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync3 <= 4'h0;
         ext_level <= 4'h0;
      end else begin
         sync1 <= ext_int;
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 4; i++) begin
            if (sync2[i] == sync3[i]) begin
               ext_level[i] <= sync3[i];
            end
         end
      end
   end

   assign edge_clear = wr && apb.paddr == `ADDR_EDGE_CLEAR ?
                       {apb.pwdata[`EDGE_CLR3_BIT], apb.pwdata[`EDGE_CLR2_BIT],
                        apb.pwdata[`EDGE_CLR1_BIT], apb.pwdata[`EDGE_CLR0_BIT]} :
                       4'h0;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         edge_seen[i] = 1'b0;
         if (sync2[i] == sync3[i] && sync3[i] != ext_level[i]) begin
            case (trig_mode_type'(external_trigger_config[2*i +: 2]))
               TRIG_RISE: edge_seen[i] = sync3[i];
               TRIG_FALL: edge_seen[i] = !sync3[i];
               default: edge_seen[i] = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         edge_pending <= 4'h0;
      end else begin
         // a new edge in the clearing cycle is kept
         edge_pending <= (edge_pending & ~edge_clear) | edge_seen;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_request <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            case (trig_mode_type'(external_trigger_config[2*i +: 2]))
               TRIG_HIGH: ext_request[i] <= ext_level[i];
               TRIG_LOW: ext_request[i] <= !ext_level[i];
               default: ext_request[i] <= edge_pending[i];
            endcase
         end
      end
   end

   sequence s_nv_read;
      rd && apb.paddr == `ADDR_NORMAL_VECTOR && nesting_control[0] && cap_pick.valid;
   endsequence

   property p_push_normal;
      @(posedge clk) disable iff (rst)
         s_nv_read |=> normal_inservice_stack[$past(cap_pick.level)];
   endproperty
   a_push_normal: assert property (p_push_normal) else $error("normal push missing");

   property p_push_fast;
      @(posedge clk) disable iff (rst)
         rd && apb.paddr == `ADDR_FAST_VECTOR && nesting_control[1] && cap_pick.valid
         |=> fast_inservice_stack[$past(cap_pick.level)];
   endproperty
   a_push_fast: assert property (p_push_fast) else $error("fast push missing");

   property p_stack_clear;
      @(posedge clk) disable iff (rst)
         wr && apb.paddr == `ADDR_NORMAL_STACK |=> normal_inservice_stack ==
         ($past(normal_inservice_stack) & ($past(normal_inservice_stack) - 8'h01));
   endproperty
   a_stack_clear: assert property (p_stack_clear) else $error("stack clear wrong");

   property p_fast_first;
      @(posedge clk) disable iff (rst) fast_irq |-> !normal_irq;
   endproperty
   a_fast_first: assert property (p_fast_first) else $error("normal beat fast");

   property p_block;
      @(posedge clk) disable iff (rst)
         normal_pick.valid && $past(nesting_control[0]) && $stable(normal_inservice_stack)
         |-> (normal_inservice_stack & upto_mask(normal_pick.level)) == 8'h00;
   endproperty
   a_block: assert property (p_block) else $error("blocked level chosen");

   property p_vec_word;
      @(posedge clk) disable iff (rst)
         pready && !apb.pwrite && apb.paddr == `ADDR_FAST_VECTOR
         |-> prdata[31:23] == 9'h0 && prdata[1:0] == 2'b00 &&
             prdata[22:7] == $past(vector_base);
   endproperty
   a_vec_word: assert property (p_vec_word) else $error("fast vector layout");

   property p_reserved;
      @(posedge clk) disable iff (rst)
         pready && !apb.pwrite && apb.paddr == `ADDR_NESTING_CONTROL |-> prdata[31:2] == 30'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_edge_from_sync;
      @(posedge clk) disable iff (rst) $rose(edge_pending[0]) |-> ext_level[0] != $past(ext_level[0]);
   endproperty
   a_edge_from_sync: assert property (p_edge_from_sync) else $error("edge without change");

   property p_edge_hold;
      @(posedge clk) disable iff (rst) edge_pending[0] && !edge_clear[0] |=> edge_pending[0];
   endproperty
   a_edge_hold: assert property (p_edge_hold) else $error("edge lost early");

   property p_high_level;
      @(posedge clk) disable iff (rst)
         external_trigger_config[1:0] == 2'b00 && $past(external_trigger_config[1:0]) == 2'b00
         |-> ext_request[0] == $past(ext_level[0]);
   endproperty
   a_high_level: assert property (p_high_level) else $error("high level mode wrong");
endmodule : vectored_interrupt_nesting

// >>> tb/irq_source_model.sv
`timescale 1ns/10ps
// peripheral side: requests and pins move only on the clock, idle in reset
module irq_source_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [19:0] set_normal,
   input wire logic [19:0] set_fast,
   input wire logic [59:0] set_levels,
   input wire logic [15:0] set_base,
   input wire logic [3:0] set_pins,
   output logic [19:0] normal_active,
   output logic [19:0] fast_active,
   output logic [59:0] other_levels,
   output logic [15:0] vector_base,
   output logic [3:0] ext_int
);
   always_ff @(posedge clk) begin
      if (rst) begin
         normal_active <= '0;
         fast_active <= '0;
         other_levels <= '0;
         vector_base <= '0;
         ext_int <= '0;
      end else begin
         normal_active <= set_normal;
         fast_active <= set_fast;
         other_levels <= set_levels;
         vector_base <= set_base;
         ext_int <= set_pins;
      end
   end
endmodule : irq_source_model

// >>> tb/vectored_interrupt_nesting_bench.sv
`timescale 1ns/10ps
`include "vic_nest_defs.svh"
module vectored_interrupt_nesting_bench;
   import vic_nest_pkg::*;
   logic clk, rst, pready, pslverr, er, normal_irq, fast_irq;
   apb_req_type apb;
   logic [31:0] prdata, rd, r, v, stk, va;
   logic [19:0] normal_active, fast_active, sn, sf;
   logic [59:0] other_levels, sl;
   logic [15:0] vector_base, sb;
   logic [3:0] ext_int, sp, ext_request;
   logic [4:0] normal_source, fast_source;
   logic [2:0] a, b;
   int fails, tests_run, k, m, p;
   logic [31:0] ra [7] = '{`ADDR_NORMAL_VECTOR, `ADDR_PRIORITY_SET_C, `ADDR_NESTING_CONTROL,
      `ADDR_EXT_TRIG_CONFIG, `ADDR_NORMAL_STACK, `ADDR_FAST_VECTOR, `ADDR_FAST_STACK};
   logic [31:0] wm [3] = '{32'h00007777, 32'h00000003, 32'h000000FF};
   logic [19:0] pat [3] = '{20'h00001, 20'h00005, 20'h00007};
   logic [3:0] tab [4] = '{4'b0010, 4'b0101, 4'b1110, 4'b0010};
   int clr [4] = '{`EDGE_CLR0_BIT, `EDGE_CLR1_BIT, `EDGE_CLR2_BIT, `EDGE_CLR3_BIT};

   vectored_interrupt_nesting vectored_interrupt_nesting_i (.clk(clk), .rst(rst), .apb(apb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .normal_active(normal_active),
      .fast_active(fast_active), .other_levels(other_levels), .vector_base(vector_base),
      .ext_int(ext_int), .ext_request(ext_request), .normal_irq(normal_irq),
      .normal_source(normal_source), .fast_irq(fast_irq), .fast_source(fast_source));
   irq_source_model irq_source_model_i (.clk(clk), .rst(rst), .set_normal(sn),
      .set_fast(sf), .set_levels(sl), .set_base(sb), .set_pins(sp),
      .normal_active(normal_active), .fast_active(fast_active),
      .other_levels(other_levels), .vector_base(vector_base), .ext_int(ext_int));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic print_verdict();
      if (fails == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // ready is read right at the rising edge, before that edge's updates land
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
      @(posedge clk);
      apb.penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("pready", 32'h1, 32'(pready));
      rd = prdata;
      er = pslverr;
      apb <= '0;
   endtask : bus

   task automatic rdchk(input string what, input logic [31:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(what, exp, rd);
   endtask : rdchk

   task automatic src(input logic [19:0] n, f, input logic [59:0] l, input logic [15:0] bs);
      @(posedge clk);
      sn <= n;
      sf <= f;
      sl <= l;
      sb <= bs;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : src

   // pin goes through the synchroniser and filter, so allow a generous settle
   task automatic pins(input logic [3:0] pv);
      @(posedge clk);
      sp <= pv;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : pins

   function automatic logic [4:0] low_idx(input logic [19:0] x);
      low_idx = 5'h00;
      for (int i = 19; i >= 0; i--) if (x[i]) low_idx = 5'(i);
   endfunction : low_idx

   function automatic logic [31:0] vec(input logic [15:0] bs, input logic [4:0] i);
      vec = {9'h0, bs, i, 2'h0};
   endfunction : vec

   initial begin
      #250000;
      fails++;
      print_verdict();
   end

   initial begin
      apb = '0;
      rst = 1'b1;
      {sn, sf, sl, sb, sp} = '0;
      fails = 0;
      tests_run = 0;
      void'($urandom(32'hEE0B));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      foreach (ra[i]) rdchk("reset", ra[i], 32'h0);
      for (k = 0; k < 3; k++) begin
         r = $urandom;
         bus(1'b1, ra[k + 1], r);
         rdchk("rw", ra[k + 1], r & wm[k]);
      end
      bus(1'b0, 32'hFFFF0040, 32'h0);
      chk("unmapped", 32'h1, 32'(er));
      // no nesting: lowest index wins, levels ignored, fast masks normal
      bus(1'b1, `ADDR_NESTING_CONTROL, 32'h0);
      repeat (16) begin
         r = $urandom & 32'hFFFFF;
         v = ($urandom & 1) ? ($urandom & 32'hFFFFF) : 32'h0;
         src(r[19:0], v[19:0], 60'({$urandom, $urandom}), 16'h0);
         chk("fast irq", 32'(v != 0), 32'(fast_irq));
         if (v != 0) chk("fast src", 32'(low_idx(v[19:0])), 32'(fast_source));
         chk("normal irq", 32'(r != 0 && v == 0), 32'(normal_irq));
         if (r != 0 && v == 0) chk("src", 32'(low_idx(r[19:0])), 32'(normal_source));
      end
      bus(1'b1, `ADDR_NESTING_CONTROL, 32'h3);
      // every source at level 1: the push sets bit 1 and then blocks the source
      bus(1'b1, `ADDR_PRIORITY_SET_C, 32'h00001111);
      for (p = 0; p < 2; p++) begin
         k = $urandom % 20;
         r = $urandom;
         stk = p ? `ADDR_FAST_STACK : `ADDR_NORMAL_STACK;
         va = p ? `ADDR_FAST_VECTOR : `ADDR_NORMAL_VECTOR;
         src(p ? 20'h0 : 20'h1 << k, p ? 20'h1 << k : 20'h0, {20{3'h1}}, r[15:0]);
         chk("active", 32'h1, 32'(p ? fast_irq : normal_irq));
         bus(1'b1, va, $urandom);
         rdchk("vector ro", va, vec(r[15:0], 5'(k)));
         rdchk("stack", stk, 32'h2);
         chk("blocked", 32'h0, 32'(p ? fast_irq : normal_irq));
         bus(1'b1, stk, 32'hFF);
         bus(1'b1, stk, 32'hFF);
      end
      bus(1'b1, `ADDR_NESTING_CONTROL, 32'h1);
      for (k = 0; k < 8; k++) begin
         a = 3'($urandom);
         b = (k == 0) ? a : 3'($urandom);
         bus(1'b1, `ADDR_PRIORITY_SET_C, {17'h0, 3'($urandom), 1'b0, 3'($urandom), 1'b0, a, 1'b0, b});
         src(20'h1 << `SRC_SPI_SLAVE | 20'h1 << `SRC_I2C_SLAVE, 20'h0, {20{3'h7}}, 16'h0);
         chk("pick", (b < a) ? `SRC_I2C_SLAVE : `SRC_SPI_SLAVE, 32'(normal_source));
      end
      // source 0 at level 3, source 1 at level 0, the rest at level 7 except the four set by priority_set_c
      for (p = 0; p < 2; p++) begin
         stk = p ? `ADDR_FAST_STACK : `ADDR_NORMAL_STACK;
         va = p ? `ADDR_FAST_VECTOR : `ADDR_NORMAL_VECTOR;
         bus(1'b1, `ADDR_NESTING_CONTROL, 32'(p + 1));
         for (k = 0; k < 3; k++) begin
            src(p ? 20'h0 : pat[k], p ? pat[k] : 20'h0, {{18{3'h7}}, 3'h0, 3'h3}, 16'h0);
            chk("irq", 32'(k != 1), 32'(p ? fast_irq : normal_irq));
            if (k != 1) rdchk("vector", va, vec(16'h0, 5'(k / 2)));
            rdchk("stack", stk, k == 2 ? 32'h9 : 32'h8);
         end
         bus(1'b1, stk, 32'hFF);
         rdchk("stack", stk, 32'h8);
         bus(1'b1, stk, 32'hFF);
         rdchk("stack", stk, 32'h0);
      end
      src(20'h0, 20'h0, '0, 16'h0);
      for (k = 0; k < 4; k++) begin
         for (m = 0; m < 4; m++) begin
            // the source counts as enabled before its trigger field is set
            bus(1'b1, `ADDR_EXT_TRIG_CONFIG, 32'(m) << (2 * k));
            pins(4'h0);
            chk("ext idle", 32'(tab[0][m]), 32'(ext_request[k]));
            pins(4'h1 << k);
            chk("ext high", 32'(tab[1][m]), 32'(ext_request[k]));
            pins(4'h0);
            chk("ext low", 32'(tab[2][m]), 32'(ext_request[k]));
            bus(1'b1, `ADDR_EDGE_CLEAR, 32'h1 << clr[k]);
            repeat (2) @(negedge clk);
            chk("ext clr", 32'(tab[3][m]), 32'(ext_request[k]));
         end
      end
      print_verdict();
   end
endmodule : vectored_interrupt_nesting_bench
